// ===== hw/asp_serial_port.sv
// serial port modes 1..3: baud select, frame transmit, voted receive
// assumes timer 1 overflow pulses and rxd arrive synchronous to aclk
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - timer rollover feeds baud, divided by sixteen
// - timer 1 path divides by 32 or 16
// - per-direction timer 2 select, else timer 1
// - timer 2 counts clk/2 from reload
// - timer 2 baud use masks flag and trigger
// - mode 1 send starts at next rollover
// - mode 1 frame: start, 8 lsb-first, stop
// - mode 1 done flag two clocks after stop
// - receive on falling edge when enabled, 16x
// - start edge resets receive sixteen counter
// - bit value is majority of three samples
// - start vote high abandons reception
// - mode 1 stop check stores byte, flag
// - failed check leaves buffer and flags
// - after mid stop return to idle
// - modes 2/3 send eleven bits with ninth
// - mode 2 rate clk/64 or clk/32
// - modes 2/3 done flag as stop placed
// - modes 2/3 accept stores ninth bit
// - mode 3 is mode 2 at timer rate
// - multiproc filter keeps ninth-bit-one frames
// - two mode bits select mode 0..3
// - done flags clear only by software
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input logic aclk,
    input logic aresetn,
    input logic [ADDR_W-1:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [ADDR_W-1:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    input logic timer1_ovf,
    input logic timer2_ovf_in,
    input logic timer2_ext_reload_trigger,
    output logic timer2_overflow_flag_set,
    output logic timer2_reload_gated,
    input logic rxd,
    output logic txd,
    output logic tx_done_flag,
    output logic rx_done_flag
);

    // register decode shared by read and write paths
    function automatic logic asp_hit(input logic [ADDR_W-1:0] a);
        return a == ASP_OFF_CTRL || a == ASP_OFF_BUF ||
               a == ASP_OFF_BAUD || a == ASP_OFF_T2RL;
    endfunction

    // three-sample majority
    function automatic logic asp_vote(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // software state
    logic [1:0] mode; // serial_mode_hi, serial_mode_lo
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic baud_doubler;
    logic tx_timer2_select;
    logic rx_timer2_select;
    logic [15:0] t2_reload; // timer2_reload_high/low
    logic [7:0] tx_hold; // serial_buffer, write side
    logic [7:0] serial_buffer; // receive side
    // bus holding registers
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_buf;
    // baud generation
    logic t1_half;
    logic t1_tick;
    logic [1:0] m2_cnt;
    logic m2_tick;
    logic t2_baud;
    logic t2_half;
    logic [15:0] t2_cnt;
    logic t2_pulse;
    logic timer_mode;
    logic tx_tick;
    logic rx_tick;
    // transmitter
    logic [3:0] tx_div;
    logic tx_roll;
    logic tx_pend;
    logic tx_busy;
    logic [3:0] tx_left;
    logic [9:0] tx_shift;
    logic tx_load;
    logic stop_ev;
    logic [ASP_TXDONE_DLY-1:0] tx_dly;
    logic ti_set;
    // receiver
    asp_rx_state_t rx_state;
    logic rxd_q;
    logic rx_start;
    logic [3:0] rx_div;
    logic [3:0] rx_idx;
    logic [1:0] rx_smp;
    logic rx_decide;
    logic rx_bit;
    logic [7:0] rx_sh;
    logic rx_ninth;
    logic rx_stop;
    logic rx_ok;
    logic rx_load;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // write channel acceptance, either order
    assign awready = !aw_got && !bvalid;
    assign wready = !w_got && !bvalid;
    assign wr_fire = aw_got && w_got && !bvalid;
    assign wr_ctrl = wr_fire && aw_addr == ASP_OFF_CTRL && w_strb[0];
    assign wr_buf = wr_fire && aw_addr == ASP_OFF_BUF && w_strb[0];
    assign arready = !rvalid;

    // hold address and data until both present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else if (wr_fire) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_got <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_got <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
        end
    end

    // write response, error on unmapped offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= ASP_RESP_OK;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= asp_hit(aw_addr) ? ASP_RESP_OK : ASP_RESP_ERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read path, one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= ASP_RD_ZERO;
            rresp <= ASP_RESP_OK;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= asp_hit(araddr) ? ASP_RESP_OK : ASP_RESP_ERR;
            rdata <= ASP_RD_ZERO;
            case (araddr)
                ASP_OFF_CTRL: begin
                    rdata[7:0] <= {mode, multiproc_enable, rx_enable,
                                   tx_ninth_bit, rx_ninth_bit,
                                   tx_done_flag, rx_done_flag};
                end
                ASP_OFF_BUF: rdata[7:0] <= serial_buffer;
                ASP_OFF_BAUD: begin
                    rdata[2:0] <= {rx_timer2_select, tx_timer2_select, baud_doubler};
                end
                ASP_OFF_T2RL: rdata[15:0] <= t2_reload;
                default: rdata <= ASP_RD_ZERO;
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // software-owned configuration bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= ASP_MODE0;
            multiproc_enable <= 1'b0;
            rx_enable <= 1'b0;
            tx_ninth_bit <= 1'b0;
            baud_doubler <= 1'b0;
            tx_timer2_select <= 1'b0;
            rx_timer2_select <= 1'b0;
            t2_reload <= '0;
        end else if (wr_fire) begin
            if (wr_ctrl) begin
                mode <= {w_data[ASP_B_MODE_HI], w_data[ASP_B_MODE_LO]};
                multiproc_enable <= w_data[ASP_B_MP];
                rx_enable <= w_data[ASP_B_REN];
                tx_ninth_bit <= w_data[ASP_B_TB8];
            end
            if (aw_addr == ASP_OFF_BAUD && w_strb[0]) begin
                baud_doubler <= w_data[ASP_B_DBL];
                tx_timer2_select <= w_data[ASP_B_TXT2];
                rx_timer2_select <= w_data[ASP_B_RXT2];
            end
            if (aw_addr == ASP_OFF_T2RL && w_strb[0]) t2_reload[7:0] <= w_data[7:0];
            if (aw_addr == ASP_OFF_T2RL && w_strb[1]) t2_reload[15:8] <= w_data[15:8];
        end
    end

    // sticky flags, hardware set beats software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_done_flag <= 1'b0;
            rx_done_flag <= 1'b0;
        end else begin
            if (ti_set) tx_done_flag <= 1'b1;
            else if (wr_ctrl) tx_done_flag <= w_data[ASP_B_TI];
            if (rx_load) rx_done_flag <= 1'b1;
            else if (wr_ctrl) rx_done_flag <= w_data[ASP_B_RI];
        end
    end

    // timer 1 overflow halved unless doubler set
    assign t1_tick = timer1_ovf && (baud_doubler || t1_half);
    // mode 2 prescale: 16x tick every 4 or 2 clocks
    assign m2_tick = m2_cnt == (baud_doubler ? ASP_M2_FAST : ASP_M2_SLOW);
    // timer 2 in baud use hides flag and reload trigger
    assign t2_baud = tx_timer2_select || rx_timer2_select;
    assign timer2_overflow_flag_set = timer2_ovf_in && !t2_baud;
    assign timer2_reload_gated = timer2_ext_reload_trigger && !t2_baud;
    // rollover from full count sends one baud pulse
    assign t2_pulse = t2_baud && t2_half && t2_cnt == ASP_T2_MAX;
    // modes 1 and 3 share the timer rate
    assign timer_mode = mode[0];
    assign tx_tick = timer_mode ? (tx_timer2_select ? t2_pulse : t1_tick)
                                : (mode[1] && m2_tick);
    assign rx_tick = timer_mode ? (rx_timer2_select ? t2_pulse : t1_tick)
                                : (mode[1] && m2_tick);

    // prescalers run in every mode; mode 0 has no tick so transmit and receive never move there
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t1_half <= 1'b0;
            m2_cnt <= '0;
        end else begin
            if (timer1_ovf) t1_half <= !t1_half;
            m2_cnt <= m2_tick ? 2'h0 : m2_cnt + 2'h1;
        end
    end

    // timer 2 counts clk/2 and reloads after full count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t2_half <= 1'b0;
            t2_cnt <= '0;
        end else if (!t2_baud) begin
            t2_half <= 1'b0;
            t2_cnt <= t2_reload;
        end else begin
            t2_half <= !t2_half;
            if (t2_half) t2_cnt <= t2_pulse ? t2_reload : t2_cnt + 16'h0001;
        end
    end

    // transmit sixteen counter, never realigned by rx
    assign tx_roll = tx_tick && tx_div == ASP_DIV_LAST;
    // load waits for a rollover, previous frame done
    assign tx_load = tx_roll && tx_pend && (!tx_busy || tx_left == 4'h0);
    assign stop_ev = tx_roll && tx_busy && tx_left == 4'h1;
    // modes 2/3 flag with stop; mode 1 delayed
    assign ti_set = (stop_ev && mode[1]) || tx_dly[ASP_TXDONE_DLY-1];

    // divide-by-16 bit clock for transmit
    always_ff @(posedge aclk) begin
        if (!aresetn) tx_div <= '0;
        else if (tx_tick) tx_div <= tx_div + 4'h1;
    end

    // pending buffer write, a new write overwrites the held byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pend <= 1'b0;
            tx_hold <= '0;
        end else if (wr_buf) begin
            tx_pend <= 1'b1;
            tx_hold <= w_data[7:0];
        end else if (tx_load) begin
            tx_pend <= 1'b0;
        end
    end

    // frame shifter; line idles high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txd <= 1'b1;
            tx_busy <= 1'b0;
            tx_left <= '0;
            tx_shift <= '1;
        end else if (tx_load) begin
            // start bit low; ninth bit before stop
            txd <= 1'b0;
            tx_busy <= 1'b1;
            tx_left <= mode[1] ? ASP_TAIL_M23 : ASP_TAIL_M1;
            tx_shift <= mode[1] ? {1'b1, tx_ninth_bit, tx_hold} : {2'b11, tx_hold};
        end else if (tx_roll && tx_busy) begin
            if (tx_left == 4'h0) begin
                tx_busy <= 1'b0;
            end else begin
                // data out lsb first, stop fills from the top
                txd <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_left <= tx_left - 4'h1;
            end
        end
    end

    // two-clock delay of the mode 1 done flag
    always_ff @(posedge aclk) begin
        if (!aresetn) tx_dly <= '0;
        else tx_dly <= {tx_dly[ASP_TXDONE_DLY-2:0], stop_ev && !mode[1]};
    end

    // start only when enabled, not mode 0, on a falling edge
    assign rx_start = rx_state == ASP_RX_IDLE && rx_enable && mode != ASP_MODE0 &&
                      rxd_q && !rxd;
    assign rx_decide = rx_state == ASP_RX_SHIFT && rx_tick && rx_div == ASP_SMP_C;
    // majority of the three middle samples
    assign rx_bit = asp_vote(rx_smp[1], rx_smp[0], rxd);
    assign rx_stop = rx_decide && rx_idx == (mode[1] ? ASP_TAIL_M23 : ASP_TAIL_M1);
    // mode 1 checks stop; modes 2/3 check ninth bit
    assign rx_ok = !rx_done_flag &&
                   (!multiproc_enable || (mode[1] ? rx_ninth : rx_bit));
    assign rx_load = rx_stop && rx_ok;

    // previous line level for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) rxd_q <= 1'b1;
        else rxd_q <= rxd;
    end

    // receive sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state <= ASP_RX_IDLE;
            rx_div <= '0;
            rx_idx <= '0;
            rx_smp <= '0;
        end else begin
            case (rx_state)
                ASP_RX_IDLE: begin
                    if (rx_start) begin
                        // realign receive counter to the edge
                        rx_state <= ASP_RX_SHIFT;
                        rx_div <= '0;
                        rx_idx <= '0;
                    end
                end
                ASP_RX_SHIFT: begin
                    if (rx_tick) rx_div <= rx_div + 4'h1;
                    if (rx_tick && (rx_div == ASP_SMP_A || rx_div == ASP_SMP_B)) begin
                        rx_smp <= {rx_smp[0], rxd};
                    end
                    if (rx_decide) begin
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == 4'h0 && rx_bit) rx_state <= ASP_RX_IDLE;
                        if (rx_stop) rx_state <= ASP_RX_IDLE;
                    end
                end
                default: rx_state <= ASP_RX_IDLE;
            endcase
        end
    end

    // data and ninth-bit capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sh <= '0;
            rx_ninth <= 1'b0;
        end else if (rx_decide && rx_idx != 4'h0) begin
            if (rx_idx < ASP_NINTH_IDX) rx_sh <= {rx_bit, rx_sh[7:1]};
            if (rx_idx == ASP_NINTH_IDX) rx_ninth <= rx_bit;
        end
    end

    // buffer moves only on acceptance; ninth field on acceptance or control write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_buffer <= '0;
            rx_ninth_bit <= 1'b0;
        end else if (rx_load) begin
            // ninth bit in modes 2/3, stop bit in mode 1
            serial_buffer <= rx_sh;
            rx_ninth_bit <= mode[1] ? rx_ninth : rx_bit;
        end else if (wr_ctrl) begin
            rx_ninth_bit <= w_data[ASP_B_RB8];
        end
    end

    sequence s_stop_m1;
        stop_ev && !mode[1];
    endsequence

    sequence s_stop_m23;
        stop_ev && mode[1];
    endsequence

    a_tx_start_low: assert property (tx_load |=> !txd && tx_busy)
        else $error("start bit not driven low");
    a_ti_mode1_delay: assert property (s_stop_m1 |=> txd ##2 tx_done_flag)
        else $error("mode 1 done flag not two clocks after stop");
    a_ti_with_stop: assert property (s_stop_m23 |=> txd && tx_done_flag)
        else $error("mode 2/3 done flag not with stop bit");
    a_ti_sticky: assert property (tx_done_flag && !wr_ctrl |=> tx_done_flag)
        else $error("transmit flag dropped without software");
    a_ri_sticky: assert property (rx_done_flag && !wr_ctrl |=> rx_done_flag)
        else $error("receive flag dropped without software");
    a_rx_align: assert property (rx_start |=> rx_div == 4'h0 && rx_idx == 4'h0)
        else $error("receive counter not realigned");
    a_start_abort: assert property (rx_decide && rx_idx == 4'h0 && rx_bit
                                    |=> rx_state == ASP_RX_IDLE)
        else $error("false start not abandoned");
    a_rx_accept: assert property (rx_load |=> rx_done_flag && serial_buffer == $past(rx_sh))
        else $error("accepted frame not stored");
    a_rx_reject: assert property (rx_stop && !rx_ok |=> $stable(serial_buffer))
        else $error("rejected frame changed buffer");
    a_mp_filter: assert property (rx_stop && mode[1] && multiproc_enable && !rx_ninth
                                  && !rx_done_flag && !wr_ctrl |=> !rx_done_flag)
        else $error("data frame passed multiprocessor filter");
    a_t2_flag_gate: assert property (t2_baud |-> !timer2_overflow_flag_set
                                     && !timer2_reload_gated)
        else $error("timer 2 flag or trigger leaked in baud use");

endmodule // asp_serial_port

// ===== hw/asp_pkg.sv
// constants and types for the asynchronous serial port (modes 1..3)
// assumes a 32-bit axi4-lite register bus and one clock
package asp_pkg;
    // register byte offsets
    localparam logic [3:0] ASP_OFF_CTRL = 4'h0;
    localparam logic [3:0] ASP_OFF_BUF = 4'h4;
    localparam logic [3:0] ASP_OFF_BAUD = 4'h8;
    localparam logic [3:0] ASP_OFF_T2RL = 4'hC;
    // control register bit positions
    localparam int ASP_B_MODE_HI = 7;
    localparam int ASP_B_MODE_LO = 6;
    localparam int ASP_B_MP = 5;
    localparam int ASP_B_REN = 4;
    localparam int ASP_B_TB8 = 3;
    localparam int ASP_B_RB8 = 2;
    localparam int ASP_B_TI = 1;
    localparam int ASP_B_RI = 0;
    // baud register bit positions
    localparam int ASP_B_DBL = 0;
    localparam int ASP_B_TXT2 = 1;
    localparam int ASP_B_RXT2 = 2;
    // mode codes
    localparam logic [1:0] ASP_MODE0 = 2'h0;
    localparam logic [1:0] ASP_MODE1 = 2'h1;
    // oversampling and vote points inside one bit
    localparam logic [3:0] ASP_DIV_LAST = 4'hF;
    localparam logic [3:0] ASP_SMP_A = 4'h7;
    localparam logic [3:0] ASP_SMP_B = 4'h8;
    localparam logic [3:0] ASP_SMP_C = 4'h9;
    // frame lengths after the start bit
    localparam logic [3:0] ASP_TAIL_M1 = 4'h9;
    localparam logic [3:0] ASP_TAIL_M23 = 4'hA;
    localparam logic [3:0] ASP_NINTH_IDX = 4'h9;
    // mode 2 prescale terminal counts (clk/64, clk/32)
    localparam logic [1:0] ASP_M2_SLOW = 2'h3;
    localparam logic [1:0] ASP_M2_FAST = 2'h1;
    localparam logic [15:0] ASP_T2_MAX = 16'hFFFF;
    localparam int ASP_TXDONE_DLY = 2;
    localparam logic [1:0] ASP_RESP_OK = 2'h0;
    localparam logic [1:0] ASP_RESP_ERR = 2'h2;
    localparam logic [31:0] ASP_RD_ZERO = 32'h0000_0000;
    typedef enum logic {ASP_RX_IDLE, ASP_RX_SHIFT} asp_rx_state_t;
endpackage

// ===== verif/asp_remote_uart.sv
// far-end serial partner: sends frames on rxd, decodes frames from txd
// assumes bit_clks and nine are set by the bench while the line is idle
`timescale 1ns/1ps
module asp_remote_uart (
    input wire logic aclk,
    input wire logic txd,
    input wire logic [7:0] bit_clks,
    input wire logic nine,
    output logic rxd,
    output logic [8:0] got,
    output logic got_stop,
    output logic [7:0] got_cnt
);
    logic [9:0] sh; // receive shift image
    initial begin
        rxd = 1'b1;
        got = '0;
        got_stop = 1'b0;
        got_cnt = '0;
    end
    task automatic send(input logic [7:0] d, input logic b9, input logic stop);
        logic [10:0] f;
        f = {stop, b9, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            rxd <= (i == (nine ? 10 : 9)) ? stop : f[i];
            repeat (bit_clks) @(posedge aclk);
        end
        // idle high before handing back
        rxd <= 1'b1;
        repeat (bit_clks) @(posedge aclk);
    endtask
    // short low pulse, too brief to survive a vote
    task automatic glitch();
        rxd <= 1'b0;
        repeat (3) @(posedge aclk);
        rxd <= 1'b1;
        repeat (2 * bit_clks) @(posedge aclk);
    endtask
    // sample mid-bit after each falling edge
    always begin
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge aclk);
        for (int i = 0; i < (nine ? 10 : 9); i++) begin
            repeat (bit_clks) @(posedge aclk);
            sh[i] = txd;
        end
        got <= {nine & sh[8], sh[7:0]};
        got_stop <= nine ? sh[9] : sh[8];
        got_cnt <= got_cnt + 8'h1;
    end
endmodule // asp_remote_uart

// ===== verif/testbench.sv
// top bench: axi4-lite master, line partner, table of baud setups
// assumes timer1_ovf pulses every cycle, so timer 1 ticks follow doubler
`timescale 1ns/1ps
module testbench;
    import asp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0; // held low eight cycles
    logic [3:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, r;
    logic [3:0] wstrb = 4'hF; // full word lanes only
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, txd, rxd;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic timer1_ovf = 1'b1; // fastest timer 1 rate
    logic timer2_ovf_in = 0, timer2_ext_reload_trigger = 0;
    logic timer2_overflow_flag_set, timer2_reload_gated, tx_done_flag, rx_done_flag;
    logic [7:0] bit_clks = 8'h10, got_cnt, c0;
    logic nine = 1'b0;
    logic [8:0] got;
    logic got_stop, txd_q = 1'b1, ti_q = 1'b0;
    int seed = 99, fail_count = 0, tests_run = 0, cycles = 0, ti_age = 0, stop_age = 0;
    asp_serial_port u_asp_serial_port (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .timer1_ovf, .timer2_ovf_in,
        .timer2_ext_reload_trigger, .timer2_overflow_flag_set, .timer2_reload_gated,
        .rxd, .txd, .tx_done_flag, .rx_done_flag);
    asp_remote_uart u_remote (.aclk, .txd, .bit_clks, .nine, .rxd, .got, .got_stop, .got_cnt);
    always #25 aclk = ~aclk;
    // random timer 2 side inputs, watchdog, done-flag latency monitor
    always @(posedge aclk) begin
        timer2_ovf_in <= $random(seed);
        timer2_ext_reload_trigger <= $random(seed);
        cycles++;
        stop_age = (txd && !txd_q) ? 0 : stop_age + 1;
        if (tx_done_flag && !ti_q) ti_age = stop_age;
        txd_q = txd;
        ti_q = tx_done_flag;
        if (cycles == 90000) begin
            fail_count++;
            $display("wrong value at %0t: run did not finish", $time);
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask
    // only aligned words answer okay
    function automatic logic [1:0] exp_resp(input logic [3:0] a);
        return (a[1:0] == 2'h0) ? ASP_RESP_OK : ASP_RESP_ERR;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel released on its own handshake
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, exp_resp(a), "bresp");
        // idle edge so a following call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk(rresp, exp_resp(a), "rresp");
        // idle edge so a following call never re-raises rready in this step
        @(posedge aclk);
    endtask
    // one baud setup: gating, transmit, receive, hold, filter
    task automatic run_cfg(input logic [1:0] m, input logic dbl, input logic [1:0] tsel,
                           input logic [15:0] rl, input logic [7:0] bc);
        logic [7:0] d;
        logic b9;
        logic [31:0] ctrl;
        d = $random(seed);
        b9 = $random(seed);
        bit_clks = bc;
        nine = m[1];
        ctrl = {24'h0, m, 1'b0, 1'b1, b9, 3'h0};
        wr(ASP_OFF_T2RL, {16'h0, rl});
        wr(ASP_OFF_BAUD, {29'h0, tsel, dbl});
        wr(ASP_OFF_CTRL, ctrl);
        rd(ASP_OFF_BAUD, r);
        chk(r, {29'h0, tsel, dbl}, "baud back");
        rd(ASP_OFF_T2RL, r);
        chk(r, {16'h0, rl}, "reload back");
        repeat (8) begin
            @(negedge aclk);
            chk(timer2_overflow_flag_set, timer2_ovf_in & (tsel == 2'h0), "t2 flag");
            chk(timer2_reload_gated, timer2_ext_reload_trigger & (tsel == 2'h0), "t2 trig");
        end
        @(posedge aclk);
        c0 = got_cnt;
        wr(ASP_OFF_BUF, {24'h0, d});
        while (got_cnt == c0) @(posedge aclk);
        chk(got, {m[1] & b9, d}, "tx frame");
        chk(got_stop, 1'b1, "tx stop");
        if ((m[1] ? b9 : d[7]) == 1'b0) chk(ti_age, (m == ASP_MODE1) ? 2 : 0, "ti time");
        u_remote.glitch();
        d = $random(seed);
        u_remote.send(d, b9, 1'b1);
        chk(rx_done_flag, 1'b1, "ri set");
        rd(ASP_OFF_BUF, r);
        chk(r, {24'h0, d}, "rx byte");
        rd(ASP_OFF_CTRL, r);
        chk(r, ctrl | {29'h0, m[1] ? b9 : 1'b1, 2'h3}, "ctrl");
        u_remote.send(~d, ~b9, 1'b1);
        rd(ASP_OFF_BUF, r);
        chk(r, {24'h0, d}, "rx hold");
        ctrl[ASP_B_MP] = 1'b1;
        wr(ASP_OFF_CTRL, ctrl);
        chk({tx_done_flag, rx_done_flag}, 2'h0, "flags clr");
        u_remote.send(d, 1'b0, m[1]);
        chk(rx_done_flag, 1'b0, "mp reject");
        // full duplex: receive realigns its counter while a frame goes out
        c0 = got_cnt;
        fork
            u_remote.send(~d, 1'b1, 1'b1);
            wr(ASP_OFF_BUF, {24'h0, ~d});
        join
        while (got_cnt == c0) @(posedge aclk);
        chk(rx_done_flag, 1'b1, "mp accept");
        chk(got, {m[1] & b9, ~d}, "duplex tx");
        wr(ASP_OFF_CTRL, 32'h0);
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ASP_OFF_CTRL, r);
        chk(r, 32'h0, "ctrl reset");
        rd(ASP_OFF_BAUD, r);
        chk(r, 32'h0, "baud reset");
        rd(4'h2, r);
        chk(r, ASP_RD_ZERO, "unmapped");
        wr(4'h6, 32'hFF);
        chk(txd, 1'b1, "idle line");
        run_cfg(ASP_MODE1, 1'b1, 2'h0, 16'h0, 8'h10);
        run_cfg(ASP_MODE1, 1'b0, 2'h0, 16'h0, 8'h20);
        run_cfg(2'h2, 1'b1, 2'h0, 16'h0, 8'h20);
        run_cfg(2'h2, 1'b0, 2'h0, 16'h0, 8'h40);
        run_cfg(2'h3, 1'b1, 2'h0, 16'h0, 8'h10);
        run_cfg(2'h3, 1'b0, 2'h1, 16'hFFFF, 8'h20);
        run_cfg(ASP_MODE1, 1'b0, 2'h2, 16'hFFFF, 8'h20);
        run_cfg(ASP_MODE1, 1'b1, 2'h3, 16'hFFFE, 8'h40);
        c0 = got_cnt;
        wr(ASP_OFF_BUF, 32'h5A);
        repeat (400) @(posedge aclk);
        chk(got_cnt, c0, "mode0 idle");
        print_verdict();
    end
endmodule // testbench
